// ===== pkg/sih_pkg.sv
package sih_pkg;

  // ****************************************************************
  // bus addressing
  // ****************************************************************
  localparam logic [6:0] SLAVE_ADDR      = 7'h5a;
  localparam logic [6:0] GCALL_ADDR      = 7'h00;
  localparam logic [7:0] GCALL_RESET_CMD = 8'h06;
  localparam int         RA_AID_BIT      = 6;

  // ****************************************************************
  // register indices
  // ****************************************************************
  localparam logic [5:0] IDX_IRQ_EN   = 6'h03;
  localparam logic [5:0] IDX_UNLOCK   = 6'h07;
  localparam logic [5:0] IDX_WAKE     = 6'h08;
  localparam logic [5:0] IDX_CMD      = 6'h18;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h21;
  localparam logic [5:0] IDX_AMB_LO   = 6'h22;
  localparam logic [5:0] IDX_AMB_HI   = 6'h23;
  localparam logic [5:0] IDX_PROX_LO  = 6'h24;
  localparam logic [5:0] IDX_PROX_HI  = 6'h25;

  // ****************************************************************
  // field positions, values, reset values
  // ****************************************************************
  localparam int         IRQ_AMB_BIT  = 0;
  localparam int         IRQ_PROX_BIT = 1;
  localparam logic [7:0] UNLOCK_VALUE = 8'h17;
  localparam logic [7:0] CMD_AMB      = 8'h01;
  localparam logic [7:0] CMD_PROX     = 8'h02;
  localparam logic [7:0] CMD_BOTH     = 8'h03;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [15:0] RES_RESET   = 16'h0000;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int MCLK_MHZ         = 200;
  localparam int INIT_TIME_US     = 25;
  localparam int INIT_CYCLES      = INIT_TIME_US * MCLK_MHZ;
  localparam int WAKE_UNIT_US     = 32;
  localparam int WAKE_UNIT_CYCLES = WAKE_UNIT_US * MCLK_MHZ;
  localparam logic [7:0] CONV_CYCLES = 8'h10;

  typedef enum logic [1:0] {
    SIH_OFF  = 2'b00,
    SIH_INIT = 2'b01,
    SIH_STBY = 2'b11,
    SIH_BUSY = 2'b10
  } sih_mode_t;

  typedef enum logic [2:0] {
    SIH_IDLE = 3'b000,
    SIH_ADDR = 3'b001,
    SIH_REGA = 3'b011,
    SIH_WDAT = 3'b010,
    SIH_RDAT = 3'b110,
    SIH_GCMD = 3'b111
  } sih_bus_t;

endpackage

// ===== hw/sih_port.sv
`timescale 1ns/100ps
module sih_port
  import sih_pkg::*;
#(
  parameter int unsigned INIT_CYCLES_P = INIT_CYCLES,
  parameter int unsigned WAKE_UNIT_P   = WAKE_UNIT_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       seq_clk,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       int_in,
  output logic            int_out,
  output logic            int_oe,
  output logic [1:0]      mode_state,
  output logic            unlocked,
  output logic            seq_awake
);

  // ****************************************************************
  // pin synchronisers and bus conditions
  // ****************************************************************
  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {scl_s1_reg, scl_s2_reg, scl_d_reg} <= 3'h7;
      {sda_s1_reg, sda_s2_reg, sda_d_reg} <= 3'h7;
    end else begin
      {scl_s1_reg, scl_s2_reg, scl_d_reg} <= {scl_in, scl_s1_reg, scl_s2_reg};
      {sda_s1_reg, sda_s2_reg, sda_d_reg} <= {sda_in, sda_s1_reg, sda_s2_reg};
    end
  end

  wire scl_rise  = scl_s2_reg & ~scl_d_reg;
  wire scl_fall  = ~scl_s2_reg & scl_d_reg;
  wire scl_high  = scl_s2_reg & scl_d_reg;
  wire bus_start = scl_high & sda_d_reg & ~sda_s2_reg;
  wire bus_stop  = scl_high & ~sda_d_reg & sda_s2_reg;

  // ****************************************************************
  // byte engine state
  // ****************************************************************
  sih_bus_t   st_reg;
  sih_mode_t  mode_reg;
  logic [7:0] sh_reg;
  logic [7:0] tx_reg;
  logic [3:0] bit_reg;
  logic       ack_ph_reg;
  logic       drv_reg;
  logic [5:0] ptr_reg;
  logic       aid_reg;
  logic [7:0] mem [0:63];
  logic [7:0] irq_reg;
  logic [15:0] amb_reg;
  logic [15:0] prox_reg;

  // ports answer only once standby is reached
  wire port_ready = (mode_reg == SIH_STBY) || (mode_reg == SIH_BUSY);
  // 7-bit compare only; a 10-bit header never matches 0x5a
  wire addr_hit   = (sh_reg[7:1] == SLAVE_ADDR) & port_ready;
  wire gc_hit     = (sh_reg[7:1] == GCALL_ADDR) & ~sh_reg[0] & port_ready;
  wire byte_done  = scl_fall & (bit_reg == 4'h8) & ~ack_ph_reg;
  wire ack_end    = scl_fall & ack_ph_reg;
  wire ack_ok     = (st_reg == SIH_ADDR) ? (addr_hit | gc_hit) :
                    ((st_reg == SIH_REGA) | (st_reg == SIH_WDAT) | (st_reg == SIH_GCMD));
  // 6-bit pointer wraps 0x3f to 0x00 by itself
  wire [5:0] ptr_adv = aid_reg ? ptr_reg : ptr_reg + 6'h01;
  wire wr_strobe  = byte_done & (st_reg == SIH_WDAT);
  wire gc_reset   = byte_done & (st_reg == SIH_GCMD) & (sh_reg == GCALL_RESET_CMD);

  // read mux: live status and results, else the plain register file
  wire [7:0] rd_byte = (ptr_reg == IDX_IRQ_STAT) ? irq_reg :
                       (ptr_reg == IDX_AMB_LO)   ? amb_reg[7:0] :
                       (ptr_reg == IDX_AMB_HI)   ? amb_reg[15:8] :
                       (ptr_reg == IDX_PROX_LO)  ? prox_reg[7:0] :
                       (ptr_reg == IDX_PROX_HI)  ? prox_reg[15:8] : mem[ptr_reg];

  // ****************************************************************
  // slave byte engine
  // ****************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg     <= SIH_IDLE;
      sh_reg     <= 8'h00;
      tx_reg     <= 8'h00;
      bit_reg    <= 4'h0;
      ack_ph_reg <= 1'b0;
      drv_reg    <= 1'b0;
      ptr_reg    <= 6'h00;
      aid_reg    <= 1'b0;
    end else if (bus_start) begin
      st_reg     <= SIH_ADDR;
      bit_reg    <= 4'h0;
      ack_ph_reg <= 1'b0;
      drv_reg    <= 1'b0;
    end else if (bus_stop) begin
      st_reg     <= SIH_IDLE;
      bit_reg    <= 4'h0;
      ack_ph_reg <= 1'b0;
      drv_reg    <= 1'b0;
    end else begin
      if (scl_rise && !ack_ph_reg) begin
        sh_reg  <= {sh_reg[6:0], sda_s2_reg};
        bit_reg <= bit_reg + 4'h1;
      end
      // master nack ends a read burst
      if (scl_rise && ack_ph_reg && st_reg == SIH_RDAT && sda_s2_reg) begin
        st_reg <= SIH_IDLE;
      end
      if (byte_done) begin
        ack_ph_reg <= 1'b1;
        drv_reg    <= ack_ok;
        bit_reg    <= 4'h0;
        case (st_reg)
          SIH_ADDR: begin
            st_reg <= addr_hit ? (sh_reg[0] ? SIH_RDAT : SIH_REGA) : (gc_hit ? SIH_GCMD : SIH_IDLE);
          end
          SIH_REGA: begin
            // bit 7 is expected zero and plays no part in decode
            ptr_reg <= sh_reg[5:0];
            aid_reg <= sh_reg[RA_AID_BIT];
            st_reg  <= SIH_WDAT;
          end
          SIH_WDAT: begin
            ptr_reg <= ptr_adv;
          end
          SIH_GCMD: begin
            st_reg <= SIH_IDLE;
          end
          default: begin
            st_reg <= st_reg;
          end
        endcase
      end
      if (ack_end) begin
        ack_ph_reg <= 1'b0;
        if (st_reg == SIH_RDAT) begin
          tx_reg  <= rd_byte;
          ptr_reg <= ptr_adv;
          drv_reg <= ~rd_byte[7];
        end else begin
          drv_reg <= 1'b0;
        end
      end
      if (scl_fall && !ack_ph_reg && st_reg == SIH_RDAT && bit_reg != 4'h8) begin
        tx_reg  <= {tx_reg[6:0], 1'b0};
        drv_reg <= ~tx_reg[6];
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = drv_reg;

  // ****************************************************************
  // crossing to and from the sequencer domain
  // ****************************************************************
  logic       req_tgl_reg;
  logic [1:0] req_cmd_reg;
  logic       done_s1_reg, done_s2_reg, done_d_reg;
  logic       done_tgl_reg;
  logic [15:0] seq_amb_reg, seq_prox_reg;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {done_s1_reg, done_s2_reg, done_d_reg} <= 3'h0;
    end else begin
      {done_s1_reg, done_s2_reg, done_d_reg} <= {done_tgl_reg, done_s1_reg, done_s2_reg};
    end
  end

  wire done_evt = done_s2_reg ^ done_d_reg;

  // ****************************************************************
  // mode control, wake timer, register file
  // ****************************************************************
  logic [31:0] init_cnt_reg;
  logic [31:0] unit_cnt_reg;
  logic [7:0]  tick_cnt_reg;
  logic        int_oe_reg;
  logic        unlocked_reg;

  wire [7:0] wake_val  = mem[IDX_WAKE];
  wire       auto_mode = wake_val != 8'h00;
  wire       unit_tick = auto_mode && unit_cnt_reg == WAKE_UNIT_P - 1;
  wire       auto_wake = unit_tick && (tick_cnt_reg + 8'h01 >= wake_val) && mode_reg == SIH_STBY;
  // a command write or the wake timer wakes the sequencer; reads never do
  wire       cmd_wr    = wr_strobe && ptr_reg == IDX_CMD;
  wire       cmd_amb   = sh_reg == CMD_AMB || sh_reg == CMD_BOTH;
  wire       cmd_prox  = sh_reg == CMD_PROX || sh_reg == CMD_BOTH;
  wire       cmd_wake  = cmd_wr && (cmd_amb || cmd_prox) && mode_reg == SIH_STBY;
  wire       irq_clr_w = wr_strobe && ptr_reg == IDX_IRQ_STAT;
  wire [7:0] irq_en    = mem[IDX_IRQ_EN];
  wire [7:0] irq_set   = (done_evt && mode_reg == SIH_BUSY) ?
                         {6'h00, req_cmd_reg[1] & irq_en[IRQ_PROX_BIT], req_cmd_reg[0] & irq_en[IRQ_AMB_BIT]} :
                         8'h00;
  // a completion in the same cycle as a clear survives
  wire [7:0] irq_next  = (irq_reg & ~(irq_clr_w ? sh_reg : 8'h00)) | irq_set;
  wire       int_live  = |(irq_next & irq_en) && mode_reg != SIH_OFF && mode_reg != SIH_INIT;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_reg     <= SIH_OFF;
      init_cnt_reg <= 32'h0;
      unit_cnt_reg <= 32'h0;
      tick_cnt_reg <= 8'h00;
      req_tgl_reg  <= 1'b0;
      req_cmd_reg  <= 2'h0;
      irq_reg      <= REG_RESET;
      amb_reg      <= RES_RESET;
      prox_reg     <= RES_RESET;
      int_oe_reg   <= 1'b0;
      unlocked_reg <= 1'b0;
      for (int i = 0; i < 64; i++) begin
        mem[i] <= REG_RESET;
      end
    end else if (gc_reset) begin
      // soft reset drops back to off; an in-flight conversion is orphaned
      mode_reg     <= SIH_OFF;
      irq_reg      <= REG_RESET;
      int_oe_reg   <= 1'b0;
      unlocked_reg <= 1'b0;
      for (int i = 0; i < 64; i++) begin
        mem[i] <= REG_RESET;
      end
    end else begin
      irq_reg      <= irq_next;
      int_oe_reg   <= int_live;
      unlocked_reg <= mem[IDX_UNLOCK] == UNLOCK_VALUE;
      if (wr_strobe && ptr_reg != IDX_IRQ_STAT) begin
        mem[ptr_reg] <= sh_reg;
      end
      unit_cnt_reg <= (unit_tick || !auto_mode) ? 32'h0 : unit_cnt_reg + 32'h1;
      if (!auto_mode || auto_wake) begin
        tick_cnt_reg <= 8'h00;
      end else if (unit_tick) begin
        tick_cnt_reg <= tick_cnt_reg + 8'h01;
      end
      case (mode_reg)
        SIH_OFF: begin
          mode_reg     <= SIH_INIT;
          init_cnt_reg <= 32'h0;
        end
        SIH_INIT: begin
          init_cnt_reg <= init_cnt_reg + 32'h1;
          if (init_cnt_reg == INIT_CYCLES_P - 1) begin
            mode_reg <= SIH_STBY;
          end
        end
        SIH_STBY: begin
          if (cmd_wake) begin
            mode_reg    <= SIH_BUSY;
            req_cmd_reg <= {cmd_prox, cmd_amb};
            req_tgl_reg <= ~req_tgl_reg;
          end else if (auto_wake) begin
            mode_reg    <= SIH_BUSY;
            req_cmd_reg <= 2'h3;
            req_tgl_reg <= ~req_tgl_reg;
          end
        end
        SIH_BUSY: begin
          if (done_evt) begin
            // results are held stable by the sequencer until the next request
            if (req_cmd_reg[0]) begin
              amb_reg <= seq_amb_reg;
            end
            if (req_cmd_reg[1]) begin
              prox_reg <= seq_prox_reg;
            end
            mode_reg <= SIH_STBY;
          end
        end
        default: begin
          mode_reg <= SIH_OFF;
        end
      endcase
    end
  end

  assign int_out    = 1'b0;
  assign int_oe     = int_oe_reg;
  assign mode_state = mode_reg;
  assign unlocked   = unlocked_reg;

  // ****************************************************************
  // conversion sequencer on its own clock
  // ****************************************************************
  logic       req_s1_reg, req_s2_reg, req_d_reg;
  logic [7:0] conv_cnt_reg;
  logic       run_reg;
  logic [15:0] sample_reg;

  wire req_evt = req_s2_reg ^ req_d_reg;

  always_ff @(posedge seq_clk or negedge nrst) begin
    if (!nrst) begin
      {req_s1_reg, req_s2_reg, req_d_reg} <= 3'h0;
      conv_cnt_reg <= 8'h00;
      run_reg      <= 1'b0;
      sample_reg   <= RES_RESET;
      seq_amb_reg  <= RES_RESET;
      seq_prox_reg <= RES_RESET;
      done_tgl_reg <= 1'b0;
    end else begin
      {req_s1_reg, req_s2_reg, req_d_reg} <= {req_tgl_reg, req_s1_reg, req_s2_reg};
      if (req_evt && !run_reg) begin
        run_reg      <= 1'b1;
        conv_cnt_reg <= CONV_CYCLES;
      end else if (run_reg) begin
        conv_cnt_reg <= conv_cnt_reg - 8'h01;
        if (conv_cnt_reg == 8'h01) begin
          run_reg      <= 1'b0;
          sample_reg   <= sample_reg + 16'h0001;
          seq_amb_reg  <= sample_reg;
          seq_prox_reg <= ~sample_reg;
          done_tgl_reg <= ~done_tgl_reg;
        end
      end
    end
  end

  assign seq_awake = run_reg;

endmodule

// ===== tb/sih_port_asserts.sv
`timescale 1ns/100ps
module sih_port_asserts
  import sih_pkg::*;
#(
  parameter int unsigned INIT_CYCLES_P = INIT_CYCLES
) (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       seq_clk,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       int_in,
  input wire logic       int_out,
  input wire logic       int_oe,
  input wire logic [1:0] mode_state,
  input wire logic       unlocked,
  input wire logic       seq_awake
);
  // ****************************************************************
  // port checks
  // ****************************************************************
  // sync latency makes the exact length fuzzy, from two cycles short to one cycle long
  localparam int INIT_LO = INIT_CYCLES_P - 2;
  localparam int INIT_HI = INIT_CYCLES_P + 1;
  logic [31:0] init_cnt;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      init_cnt <= 32'h0;
    else if (mode_state == SIH_INIT)
      init_cnt <= init_cnt + 32'h1;
    else
      init_cnt <= 32'h0;
  end
  sequence s_init_end;
    (mode_state == SIH_INIT) ##1 (mode_state == SIH_STBY);
  endsequence
  sequence s_off_step;
    (mode_state == SIH_OFF) ##[1:4] (mode_state == SIH_INIT);
  endsequence
  property p_tie; sda_out == 1'b0 && int_out == 1'b0; endproperty
  property p_int_init; mode_state == SIH_INIT |-> !int_oe; endproperty
  property p_init_len; s_init_end |-> $past(init_cnt) >= INIT_LO && $past(init_cnt) <= INIT_HI; endproperty
  property p_init_max; init_cnt <= INIT_HI; endproperty
  property p_off_next; mode_state == SIH_OFF |-> s_off_step; endproperty
  property p_stby_next; $past(mode_state) == SIH_STBY |-> mode_state != SIH_INIT; endproperty
  property p_busy_next; mode_state == SIH_BUSY |=> mode_state != SIH_INIT; endproperty
  property p_awake; $rose(seq_awake) |-> mode_state == SIH_BUSY; endproperty
  property p_sda_chg; $changed(sda_oe) |-> !$past(scl_in) && !$past(scl_in, 2); endproperty
  property p_unlock; mode_state == SIH_INIT && $past(mode_state) == SIH_INIT |-> !unlocked; endproperty
  property p_int_rise; $rose(int_oe) |-> $past(mode_state) == SIH_BUSY || $past(mode_state, 2) == SIH_BUSY; endproperty
  a_tie: assert property (p_tie) else $error("open drain data not zero");
  a_int_init: assert property (p_int_init) else $error("interrupt during init");
  a_init_len: assert property (p_init_len) else $error("init length wrong");
  a_init_max: assert property (p_init_max) else $error("init too long");
  a_off_next: assert property (p_off_next) else $error("off not followed by init");
  a_stby_next: assert property (p_stby_next) else $error("standby jumped to init");
  a_busy_next: assert property (p_busy_next) else $error("busy jumped to init");
  a_awake: assert property (p_awake) else $error("sequencer woke outside busy");
  a_sda_chg: assert property (p_sda_chg) else $error("sda changed with scl high");
  a_unlock: assert property (p_unlock) else $error("unlock kept over reset");
  a_int_rise: assert property (p_int_rise) else $error("interrupt without conversion");
endmodule

bind sih_port sih_port_asserts #(.INIT_CYCLES_P(INIT_CYCLES_P)) u_sih_port_asserts (.mclk(mclk), .nrst(nrst),
  .seq_clk(seq_clk), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .int_in(int_in),
  .int_out(int_out), .int_oe(int_oe), .mode_state(mode_state), .unlocked(unlocked), .seq_awake(seq_awake));

// ===== tb/sih_host.sv
`timescale 1ns/100ps
module sih_host (
  input  wire logic mclk,
  input  wire logic sda_line,
  output logic      scl_o,
  output logic      sda_low
);
  // ****************************************************************
  // bus master model, third of a bit of 8 mclk
  // ****************************************************************
  initial begin
    scl_o = 1'b1;
    sda_low = 1'b0;
  end
  task automatic put(input logic c, input logic d);
    scl_o <= c;
    sda_low <= d;
    repeat (8) @(posedge mclk);
  endtask
  // also serves as repeated start: sda released before scl rises
  task automatic start();
    put(scl_o, 1'b0);
    put(1'b1, 1'b0);
    put(1'b1, 1'b1);
    put(1'b0, 1'b1);
  endtask
  task automatic stop();
    put(1'b0, 1'b1);
    put(1'b1, 1'b1);
    put(1'b1, 1'b0);
  endtask
  task automatic bitx(input logic d, output logic s);
    put(1'b0, !d);
    put(1'b1, !d);
    s = sda_line;
    put(1'b0, !d);
  endtask
  // writes pass last=1 to read the ack; reads pass 8'hff and last=1 for nack
  task automatic xfer(input logic [7:0] w, input logic last, output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(w[i], s);
      r[i] = s;
    end
    bitx(last, s);
    ack = !s;
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/100ps
module tb;
  import sih_pkg::*;
  // ****************************************************************
  // bench
  // ****************************************************************
  logic       mclk, nrst, seq_clk, scl_o, sda_low, sda_line, int_line;
  logic       sda_out, sda_oe, int_out, int_oe, unlocked, seq_awake;
  logic [1:0] mode_state;
  logic [7:0] mem [64];
  logic [7:0] irq_exp;
  logic [15:0] amb_exp, prox_exp;
  int         bad_count, samples_checked;
  assign sda_line = !sda_low && (sda_oe ? sda_out : 1'b1);
  assign int_line = int_oe ? int_out : 1'b1;
  sih_port #(.INIT_CYCLES_P(20), .WAKE_UNIT_P(8)) u_sih_port (.mclk(mclk), .nrst(nrst), .seq_clk(seq_clk),
    .scl_in(scl_o), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .int_in(int_line), .int_out(int_out),
    .int_oe(int_oe), .mode_state(mode_state), .unlocked(unlocked), .seq_awake(seq_awake));
  sih_host u_sih_host (.mclk(mclk), .sda_line(sda_line), .scl_o(scl_o), .sda_low(sda_low));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    seq_clk = 1'b0;
    #17.3;
    forever #40 seq_clk = ~seq_clk;
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // live status and result indices answer from the model, the rest from the register image
  function automatic logic [7:0] exp_at(input logic [5:0] p);
    case (p)
      IDX_IRQ_STAT: exp_at = irq_exp;
      IDX_AMB_LO:   exp_at = amb_exp[7:0];
      IDX_AMB_HI:   exp_at = amb_exp[15:8];
      IDX_PROX_LO:  exp_at = prox_exp[7:0];
      IDX_PROX_HI:  exp_at = prox_exp[15:8];
      default:      exp_at = mem[p];
    endcase
  endfunction
  task automatic addr_only(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    logic       k;
    u_sih_host.start();
    u_sih_host.xfer(a, 1'b1, r, k);
    chk("address ack", exp, k);
    u_sih_host.stop();
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] d [$]);
    logic [7:0] r;
    logic       k;
    logic [5:0] p;
    p = ra[5:0];
    u_sih_host.start();
    u_sih_host.xfer({SLAVE_ADDR, 1'b0}, 1'b1, r, k);
    chk("address ack", 8'h1, k);
    u_sih_host.xfer(ra, 1'b1, r, k);
    foreach (d[i]) begin
      u_sih_host.xfer(d[i], 1'b1, r, k);
      chk("data ack", 8'h1, k);
      mem[p] = d[i];
      if (!ra[RA_AID_BIT])
        p = p + 6'h1;
    end
    u_sih_host.stop();
  endtask
  task automatic rd(input logic [7:0] ra, input int n);
    logic [7:0] r, e;
    logic       k;
    logic [5:0] p;
    p = ra[5:0];
    u_sih_host.start();
    u_sih_host.xfer({SLAVE_ADDR, 1'b0}, 1'b1, r, k);
    u_sih_host.xfer(ra, 1'b1, r, k);
    u_sih_host.start();
    u_sih_host.xfer({SLAVE_ADDR, 1'b1}, 1'b1, r, k);
    for (int i = 0; i < n; i++) begin
      u_sih_host.xfer(8'hff, i == n - 1, r, k);
      e = exp_at(p);
      chk("read data", e, r);
      if (!ra[RA_AID_BIT])
        p = p + 6'h1;
    end
    u_sih_host.stop();
  endtask
  task automatic wait_mode(input logic [1:0] m, input int lim);
    int n;
    n = 0;
    while (mode_state !== m && n < lim) begin
      @(posedge mclk);
      n++;
    end
    chk("mode", m, mode_state);
  endtask
  task automatic gcall();
    logic [7:0] r;
    logic       k;
    addr_only(8'h00, 8'h1);
    u_sih_host.start();
    u_sih_host.xfer({GCALL_ADDR, 1'b0}, 1'b1, r, k);
    u_sih_host.xfer(GCALL_RESET_CMD, 1'b1, r, k);
    chk("reset command ack", 8'h1, k);
    u_sih_host.stop();
    foreach (mem[i])
      mem[i] = REG_RESET;
    irq_exp = 8'h00;
    wait_mode(SIH_STBY, 200);
  endtask
  initial begin
    logic [7:0] cmd_t [3];
    logic [7:0] en_t [3];
    cmd_t = '{CMD_AMB, CMD_PROX, CMD_BOTH};
    en_t = '{8'h02, 8'h03, 8'h03};
    nrst = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    amb_exp = RES_RESET;
    prox_exp = RES_RESET;
    void'($urandom(32'h725a6adc));
    // the sequencer domain needs two of its own edges inside reset as well
    repeat (2) @(posedge seq_clk);
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("mode", SIH_INIT, mode_state);
    wait_mode(SIH_STBY, 100);
    chk("awake", 8'h0, seq_awake);
    gcall();
    wr({2'b00, IDX_UNLOCK}, '{UNLOCK_VALUE});
    chk("unlocked", 8'h1, unlocked);
    wr(8'h3e, '{$urandom, $urandom, $urandom, $urandom});
    rd(8'h3e, 4);
    wr(8'h50, '{$urandom, $urandom});
    rd(8'h50, 3);
    chk("mode", SIH_STBY, mode_state);
    addr_only({SLAVE_ADDR + 7'h1, 1'b0}, 8'h0);
    addr_only(8'hf0, 8'h0);
    addr_only({GCALL_ADDR, 1'b1}, 8'h0);
    for (int i = 0; i < 3; i++) begin
      wr({2'b00, IDX_IRQ_EN}, '{en_t[i]});
      wr({2'b00, IDX_CMD}, '{cmd_t[i]});
      chk("mode", SIH_BUSY, mode_state);
      wait_mode(SIH_STBY, 800);
      // conversion k reports k as ambient and its inverse as proximity
      if (cmd_t[i][0])
        amb_exp = 16'(i);
      if (cmd_t[i][1])
        prox_exp = ~16'(i);
      irq_exp = cmd_t[i] & en_t[i];
      repeat (50) @(posedge mclk);
      chk("int", irq_exp != 8'h00, int_oe);
      rd({2'b00, IDX_AMB_LO}, 4);
      rd({2'b01, IDX_IRQ_STAT}, 1);
      wr({2'b00, IDX_IRQ_STAT}, '{8'hff});
      irq_exp = 8'h00;
      repeat (2) @(posedge mclk);
      chk("int", 8'h0, int_oe);
    end
    wr({2'b00, IDX_WAKE}, '{8'h01});
    wait_mode(SIH_BUSY, 400);
    wr({2'b00, IDX_WAKE}, '{8'h00});
    wait_mode(SIH_STBY, 800);
    repeat (100) @(posedge mclk);
    chk("mode", SIH_STBY, mode_state);
    gcall();
    chk("unlocked", 8'h0, unlocked);
    rd(8'h3e, 1);
    finish_test();
  end
  initial begin
    #300000;
    bad_count++;
    finish_test();
  end
endmodule
